// ### logic/lpi_defines.svh
// Constants for the LED PWM intensity and blink block
`ifndef LPI_DEFINES_SVH
`define LPI_DEFINES_SVH
// ==========================================================
// Intensity codes and combined register layout
`define LPI_CODE_STATIC   4'hf
`define LPI_CODE_HALF     4'h7
`define LPI_MASTER_OFF    4'h0
`define LPI_MASTER_MSB    7
`define LPI_MASTER_LSB    4
`define LPI_GLOBAL_MSB    3
`define LPI_GLOBAL_LSB    0
`define LPI_INTENS_RESET  8'h00
// ==========================================================
// PWM frame: 16 sub-slots per master slot, 15 master slots
`define LPI_SUB_LAST      4'hf
`define LPI_SLOT_LAST     4'he
`define LPI_AUX_INDEX     16
// ==========================================================
// Timing: one PWM sub-slot lasts this long
`define LPI_CLK_PERIOD_NS 10
`define LPI_SLICE_NS      40
`define LPI_SLICE_CYCLES  (`LPI_SLICE_NS / `LPI_CLK_PERIOD_NS)
`endif

// ### logic/lpi_pkg.sv
// Types shared by the LED PWM intensity and blink block
package lpi_pkg;
	// ==========================================================
	// Types
	typedef logic [3:0] lpi_code_t;
	typedef logic [7:0] lpi_intens_t;
	typedef enum logic [0:0] {
		LPI_STOPPED = 1'b0,
		LPI_RUNNING = 1'b1
	} lpi_osc_e;
endpackage

// ### logic/lpi_pwm.sv
// LED PWM intensity generator with two-phase blink level select
`timescale 1ns/100ps
`include "lpi_defines.svh"

module lpi_pwm #(
	parameter int NUM_PORTS    = 16,
	parameter int SLICE_CYCLES = `LPI_SLICE_CYCLES
) (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// Configuration
	input  wire logic                      global_mode,
	input  wire logic                      blink_enable,
	input  wire logic                      blink_phase,
	input  wire logic [NUM_PORTS:0]        phase0_level,
	input  wire logic [NUM_PORTS:0]        phase1_level,
	input  wire logic [NUM_PORTS*4-1:0]    port_intensity,
	// Combined master and auxiliary intensity register
	input  wire logic                      intens_wr,
	input  wire lpi_pkg::lpi_intens_t      intens_wdata,
	output lpi_pkg::lpi_intens_t           intens_rdata,
	// Open-drain pins, index NUM_PORTS is the auxiliary output
	output logic      [NUM_PORTS:0]        pin_out,
	output logic      [NUM_PORTS:0]        pin_oe,
	// Status
	output logic                           osc_running
);
	import lpi_pkg::*;

	// ==========================================================
	// Functions

	// Low-drive decision for one pin; code F bypasses PWM entirely
	function automatic logic drive_low(input lpi_code_t code, input logic level,
			input logic run, input logic active, input lpi_code_t sub);
		logic low_win;
		low_win = (sub <= code);
		if (code == `LPI_CODE_STATIC)
			drive_low = ~level;
		else if (!run)
			drive_low = 1'b0;
		else
			drive_low = active & (low_win ^ level);
	endfunction

	// ==========================================================
	// Combined intensity register

	lpi_intens_t intens;
	lpi_code_t   master;
	lpi_code_t   aux_code;

	assign master   = intens[`LPI_MASTER_MSB:`LPI_MASTER_LSB];
	assign aux_code = intens[`LPI_GLOBAL_MSB:`LPI_GLOBAL_LSB];

	// Written whole, read back whole
	always_ff @(posedge ref_clk) begin
		if (rst)
			intens <= `LPI_INTENS_RESET;
		else if (intens_wr)
			intens <= intens_wdata;
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			intens_rdata <= `LPI_INTENS_RESET;
		else if (intens_wr)
			intens_rdata <= intens_wdata;
		else
			intens_rdata <= intens;
	end

	// ==========================================================
	// Oscillator state and PWM frame counters

	lpi_osc_e  osc;
	lpi_osc_e  next_osc;
	logic [$clog2(SLICE_CYCLES+1)-1:0] pre;
	lpi_code_t sub;
	lpi_code_t slot;
	logic      tick;

	// Master zero parks the oscillator so nothing toggles
	always_comb begin
		case (osc)
			LPI_STOPPED: next_osc = (master != `LPI_MASTER_OFF) ? LPI_RUNNING : LPI_STOPPED;
			LPI_RUNNING: next_osc = (master == `LPI_MASTER_OFF) ? LPI_STOPPED : LPI_RUNNING;
			default:     next_osc = LPI_STOPPED;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			osc <= LPI_STOPPED;
		else
			osc <= next_osc;
	end

	assign tick = (pre == ($bits(pre))'(SLICE_CYCLES - 1));

	// Prescaler sets the length of one sixteenth
	always_ff @(posedge ref_clk) begin
		if (rst || osc == LPI_STOPPED || tick)
			pre <= '0;
		else
			pre <= pre + 1'b1;
	end

	// Sixteen sub-slots per master slot, fifteen master slots per frame
	always_ff @(posedge ref_clk) begin
		if (rst || osc == LPI_STOPPED) begin
			sub  <= '0;
			slot <= '0;
		end else if (tick) begin
			sub <= sub + 1'b1;
			if (sub == `LPI_SUB_LAST)
				slot <= (slot == `LPI_SLOT_LAST) ? '0 : slot + 1'b1;
		end
	end

	// ==========================================================
	// Per-pin drive

	logic [NUM_PORTS:0] next_oe;
	logic               master_active;

	// Master value M lets the first M of 15 slots carry PWM
	assign master_active = (slot < master);

	always_comb begin
		lpi_code_t code;
		logic      level;
		code    = '0;
		level   = 1'b0;
		next_oe = '0;
		for (int i = 0; i <= NUM_PORTS; i++) begin
			if (global_mode || i == NUM_PORTS)
				code = aux_code;
			else
				code = port_intensity[i*4 +: 4];
			// Blink phase picks the on-time level bit
			level = (blink_enable && blink_phase) ? phase1_level[i]
			                                      : phase0_level[i];
			next_oe[i] = drive_low(code, level, osc == LPI_RUNNING, master_active, sub);
		end
	end

	// Pins only ever sink; the data line stays low and the enable switches
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_oe  <= '0;
			pin_out <= '0;
		end else begin
			pin_oe  <= next_oe;
			pin_out <= '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			osc_running <= 1'b0;
		else
			osc_running <= (next_osc == LPI_RUNNING);
	end

	// ==========================================================
	// Assertions

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	static_low_a: assert property (
		(port_intensity[3:0] == `LPI_CODE_STATIC && !global_mode && !blink_enable
		 && !phase0_level[0]) |=> pin_oe[0])
		else $error("static code with level 0 not held low");

	static_off_a: assert property (
		(port_intensity[3:0] == `LPI_CODE_STATIC && !global_mode && !blink_enable
		 && phase0_level[0]) |=> !pin_oe[0])
		else $error("static code with level 1 not released");

	phase_one_a: assert property (
		(port_intensity[3:0] == `LPI_CODE_STATIC && !global_mode && blink_enable
		 && blink_phase && !phase1_level[0] && phase0_level[0]) |=> pin_oe[0])
		else $error("phase 1 level bit not used");

	min_duty_a: assert property (
		(osc == LPI_RUNNING && master_active && sub == 4'h0 && !global_mode
		 && !blink_enable && !phase0_level[0]) |=> pin_oe[0])
		else $error("level 0 pin not low in first sixteenth");

	max_off_a: assert property (
		(osc == LPI_RUNNING && master_active && sub == 4'h0 && !global_mode
		 && !blink_enable && phase0_level[0]
		 && port_intensity[3:0] != `LPI_CODE_STATIC) |=> !pin_oe[0])
		else $error("level 1 pin low in first sixteenth");

	half_duty_a: assert property (
		(osc == LPI_RUNNING && master_active && !global_mode && !blink_enable
		 && !phase0_level[0] && port_intensity[3:0] == `LPI_CODE_HALF)
		|=> (pin_oe[0] == $past(sub < 4'h8)))
		else $error("half code duty wrong");

	global_same_a: assert property (
		(global_mode && !blink_enable && phase0_level[0] == phase0_level[NUM_PORTS])
		|=> (pin_oe[0] == pin_oe[NUM_PORTS]))
		else $error("global mode pins differ");

	master_stop_a: assert property (
		(master == `LPI_MASTER_OFF && !intens_wr)[*3] |-> (!osc_running && sub == 4'h0))
		else $error("oscillator runs with master zero");

	readback_a: assert property (
		intens_wr |=> (intens_rdata == $past(intens_wdata)))
		else $error("intensity readback mismatch");

	never_drive_a: assert property (pin_out == '0)
		else $error("open-drain data line driven high");

	// Main scenarios
	cover_global_c: cover property (global_mode && osc == LPI_RUNNING ##1 pin_oe[0]);
	cover_blink_c:  cover property (blink_enable && blink_phase ##1 pin_oe[NUM_PORTS]);
	cover_wrap_c:   cover property (tick && sub == `LPI_SUB_LAST && slot == `LPI_SLOT_LAST);
	cover_stop_c:   cover property (osc == LPI_RUNNING ##1 osc == LPI_STOPPED);
endmodule

// ### tb/lpi_led_model.sv
// Far side of the open-drain pins: pulled-up loads with LEDs to the rail
`timescale 1ns/100ps

// ==========================================================
// Pad model
module lpi_led_model #(
	parameter int N = 17
) (
	// Pin drivers from the block
	input  wire logic [N-1:0] pin_out,
	input  wire logic [N-1:0] pin_oe,
	// Resolved pad levels, low means the LED is lit
	output logic      [N-1:0] pad
);
	// A released pin floats up through its resistor, never to the last value
	assign pad = (pin_oe & pin_out) | ~pin_oe;
endmodule

// ### tb/led_pwm_intensity_blink_tb_top.sv
// Self-checking bench for the LED PWM intensity block, duty counted per frame
`timescale 1ns/100ps

module led_pwm_intensity_blink_tb_top;
	import lpi_pkg::*;
	// ==========================================================
	// Signals
	localparam int SLICE = 1;
	localparam int FRAME = 15 * 16 * SLICE;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        global_mode = 1'b0;
	logic        blink_enable = 1'b0;
	logic        blink_phase = 1'b0;
	logic        intens_wr = 1'b0;
	logic [16:0] phase0_level = '0;
	logic [16:0] phase1_level = '0;
	logic [63:0] port_intensity = '0;
	lpi_intens_t intens_wdata = 8'h00;
	lpi_intens_t intens_rdata;
	logic [16:0] pin_out;
	logic [16:0] pin_oe;
	logic [16:0] pad;
	logic        osc_running;
	int          errors = 0;
	int          checked = 0;
	int          cnt [17];

	// Free-running clock, 10 ns period
	always #5 ref_clk = ~ref_clk;

	// ==========================================================
	// Block and loads
	lpi_pwm #(.NUM_PORTS(16), .SLICE_CYCLES(SLICE)) DUT (
		.ref_clk(ref_clk), .rst(rst), .global_mode(global_mode),
		.blink_enable(blink_enable), .blink_phase(blink_phase),
		.phase0_level(phase0_level), .phase1_level(phase1_level),
		.port_intensity(port_intensity), .intens_wr(intens_wr),
		.intens_wdata(intens_wdata), .intens_rdata(intens_rdata),
		.pin_out(pin_out), .pin_oe(pin_oe), .osc_running(osc_running));
	lpi_led_model #(.N(17)) LED (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

	// ==========================================================
	// Helpers
	task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	task close_out;
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Single-cycle write strobe on the combined register
	task wr(input lpi_intens_t v);
		@(posedge ref_clk);
		intens_wr    <= 1'b1;
		intens_wdata <= v;
		@(posedge ref_clk);
		intens_wr    <= 1'b0;
	endtask

	// Lit cycles per frame; frame phase does not matter over a whole frame
	function int exp_cnt(int m, int n, bit l);
		if (n == 15) return l ? 0 : FRAME;
		if (m == 0) return 0;
		return l ? SLICE * m * (15 - n) : SLICE * m * (n + 1);
	endfunction

	// ==========================================================
	// Main sequence: random settings, master zero and full scale forced
	initial begin
		lpi_intens_t w;
		int          n;
		bit          l;
		bit          rg;
		bit          rb;
		bit          rp;
		logic [16:0] r0;
		logic [16:0] r1;
		logic [63:0] rpi;
		void'($urandom(1));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		// Reset leaves the register clear, the oscillator parked and every pad released
		@(negedge ref_clk);
		chk("rst_rdata", 0, intens_rdata);
		chk("rst_osc", 0, osc_running);
		chk("rst_pad", 17'h1ffff, pad);
		for (int it = 0; it < 16; it++) begin
			@(posedge ref_clk);
			rg  = 1'($urandom);
			rb  = 1'($urandom);
			rp  = 1'($urandom);
			r0  = 17'($urandom);
			r1  = 17'($urandom);
			rpi = {$urandom, $urandom};
			w   = 8'($urandom);
			if (it % 5 == 0) w[7:4] = 4'h0;
			if (it == 1) w = 8'hf7;
			// Pin 0 corners, else random draws would rarely reach the guarded cases
			if (it >= 2 && it <= 6) begin
				rg        = 1'b0;
				rb        = (it == 2);
				rp        = 1'b1;
				r0[0]     = (it != 3 && it != 6);
				r1[0]     = 1'b0;
				rpi[3:0]  = (it == 3 || it == 5) ? 4'h7 : 4'hf;
				w[7:4]    = 4'he;
			end
			// Global mode with matching level bits on pin 0 and the auxiliary pin
			if (it == 7) begin
				rg     = 1'b1;
				rb     = 1'b0;
				r0[16] = r0[0];
			end
			global_mode    <= rg;
			blink_enable   <= rb;
			blink_phase    <= rp;
			phase0_level   <= r0;
			phase1_level   <= r1;
			port_intensity <= rpi;
			wr(w);
			repeat (3) @(posedge ref_clk);
			@(negedge ref_clk);
			chk("intens_rdata", w, intens_rdata);
			chk("osc_running", w[7:4] != 4'h0, osc_running);
			for (int i = 0; i < 17; i++) cnt[i] = 0;
			repeat (FRAME) begin
				@(negedge ref_clk);
				for (int i = 0; i < 17; i++) if (pad[i] === 1'b0) cnt[i]++;
			end
			for (int i = 0; i < 17; i++) begin
				n = (global_mode || i == 16) ? w[3:0] : port_intensity[4*i+:4];
				l = (blink_enable && blink_phase) ? phase1_level[i] : phase0_level[i];
				chk($sformatf("pin%0d", i), exp_cnt(w[7:4], n, l), cnt[i]);
			end
		end
		close_out;
	end
endmodule
